// ===== adc_ctl_consts.vh
// Constants for the converter control and flag block
`ifndef ADC_CTL_CONSTS_VH
`define ADC_CTL_CONSTS_VH

// Register word offsets inside one 16-byte register page
`define OFF_CTL2 4'h0
`define OFF_CTL3 4'h4
`define OFF_CTL4 4'h8
`define OFF_CTL5 4'hC
// Second register page inside the block set
`define OFF_STAT 4'h0
`define OFF_PORT 4'h4
`define OFF_RSLT 4'h8
// Block layout: bit 4 selects the page, bit 5 selects the instance
`define PAGE_BIT 4
`define INST_BIT 5
`define RSLT_SEL_LSB 2

// Control two field positions
`define C2_PWR 7
`define C2_FAST_FLAG_CLEAR 6
`define C2_HALTW 5
`define C2_JUST 4
`define C2_IE 1
`define C2_IFLAG 0
// Control four field position
`define C4_RESOLUTION_SELECT 7
// Control five sequence start pattern
`define C5_CHAN_LSB 0
`define C5_CHAN_MSB 2

// Reset values
`define CTL_RESET 8'h00

// Conversion length in clocks
`define CONV_CYCLES 8'h0E

// AHB transfer type
`define HTRANS_NONSEQ 2'h2

`endif

// ===== adc_control_flags_port.v
// Two-instance converter control, flags, justification and digital input port
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Eight-bit input-only port, no direction register
// - Analog pins also readable as digital levels
// - Port reads never disturb running conversions
// - Two instances, each 32-byte register block
// - Control two/three writes never restart sequences
// - Clearing power-up aborts and powers down
// - Normal clear: status read then result read
// - Fast clear: any result access clears
// - Normal mode: new sequence clears sequence flag
// - Fast mode: first result read clears it
// - Wait halt bit freezes converter in wait
// - Ten-bit results at bits 6-15 or 0-9
// - Eight-bit results in high or low byte
// - Enable gates sequence-done interrupt request
// - Interrupt flag holds until clear, restart, reset
// - Interrupt flag ignores software writes
// - Module reset cancels pending interrupt
// - Control four/five write restarts and clears flags

`include "adc_ctl_consts.vh"

module adc_control_flags_port #(
    parameter NUM_CONV = 4,
    parameter CONV_CYCLES = 14
)
(
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // AHB-Lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Analog pins seen digitally, one byte per instance
    input wire [7:0] pin_level_0,
    input wire [7:0] pin_level_1,
    // Converter result words from the analog core, one per instance
    input wire [9:0] sar_result_0,
    input wire [9:0] sar_result_1,
    // Processor wait mode
    input wire cpu_wait,
    // Interrupt requests and power state per instance
    output reg [1:0] irq,
    output reg [1:0] analog_powered
);

    ////////////////////////////////////////////////////////////////////////////
    // Address phase capture
    reg ap_valid_reg;
    reg ap_write_reg;
    reg [7:0] ap_addr_reg;
    wire take = hsel && hready && (htrans == `HTRANS_NONSEQ);

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            ap_valid_reg <= take;
            ap_write_reg <= hwrite;
            ap_addr_reg <= haddr;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Decoded data-phase strobes
    // two instance blocks
    wire ap_inst = ap_addr_reg[`INST_BIT];
    wire ap_page = ap_addr_reg[`PAGE_BIT];
    wire [3:0] ap_off = ap_addr_reg[3:0];
    wire wr_now = ap_valid_reg && ap_write_reg;
    wire rd_now = ap_valid_reg && !ap_write_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Per-instance control and flag state
    reg [7:0] ctl2_reg [0:1];
    reg [7:0] ctl3_reg [0:1];
    reg [7:0] ctl4_reg [0:1];
    reg [7:0] ctl5_reg [0:1];
    reg [NUM_CONV-1:0] ccf_reg [0:1];
    reg [1:0] seq_done_reg;
    reg [1:0] iflag_reg;
    reg [NUM_CONV-1:0] stat_armed_reg [0:1];
    reg [1:0] first_read_reg;
    reg [1:0] busy_reg;
    reg [7:0] cyc_reg [0:1];
    reg [1:0] conv_idx_reg [0:1];
    reg [9:0] result_reg [0:1][0:NUM_CONV-1];

    integer i;
    integer k;
    integer j;

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (i = 0; i < 2; i = i + 1)
            begin
                ctl2_reg[i] <= `CTL_RESET;
                ctl3_reg[i] <= `CTL_RESET;
                ctl4_reg[i] <= `CTL_RESET;
                ctl5_reg[i] <= `CTL_RESET;
                ccf_reg[i] <= {NUM_CONV{1'b0}};
                stat_armed_reg[i] <= {NUM_CONV{1'b0}};
                cyc_reg[i] <= 8'h00;
                conv_idx_reg[i] <= 2'b00;
                for (k = 0; k < NUM_CONV; k = k + 1)
                    result_reg[i][k] <= 10'h000;
            end
            seq_done_reg <= 2'b00;
            iflag_reg <= 2'b00;
            first_read_reg <= 2'b00;
            busy_reg <= 2'b00;
        end
        else
        begin
            for (i = 0; i < 2; i = i + 1)
            begin : inst
                reg sel;
                reg halted;
                reg rd_idx_ok;
                reg [1:0] ridx;
                reg done_now;
                sel = (ap_inst == i[0]);
                ridx = ap_off[3:2];
                halted = ctl2_reg[i][`C2_HALTW] && cpu_wait;
                rd_idx_ok = 1'b0;
                done_now = 1'b0;
                // Conversion engine: halted but not reset during wait
                // wait halt freeze
                if (busy_reg[i] && ctl2_reg[i][`C2_PWR] && !halted)
                begin
                    if (cyc_reg[i] == CONV_CYCLES[7:0] - 8'h01)
                    begin
                        cyc_reg[i] <= 8'h00;
                        result_reg[i][conv_idx_reg[i]] <= (i == 0) ? sar_result_0 : sar_result_1;
                        ccf_reg[i][conv_idx_reg[i]] <= 1'b1;
                        conv_idx_reg[i] <= conv_idx_reg[i] + 2'b01;
                        if (conv_idx_reg[i] == NUM_CONV[1:0] - 2'b01)
                        begin
                            busy_reg[i] <= 1'b0;
                            done_now = 1'b1;
                            seq_done_reg[i] <= 1'b1;
                            iflag_reg[i] <= 1'b1;
                        end
                    end
                    else
                        cyc_reg[i] <= cyc_reg[i] + 8'h01;
                end
                if (!ctl2_reg[i][`C2_PWR])
                    busy_reg[i] <= 1'b0;
                // Arm only the flags the status read shows set, so a later flag needs a fresh read
                // status read arming
                if (take && !hwrite && haddr[`INST_BIT] == i[0] && haddr[`PAGE_BIT] && haddr[3:0] == `OFF_STAT)
                    stat_armed_reg[i] <= ccf_reg[i];
                // Result access flag clearing
                if (ap_valid_reg && sel && ap_page && ap_off[3] && ccf_reg[i][ridx])
                begin
                    if (ctl2_reg[i][`C2_FAST_FLAG_CLEAR])
                        rd_idx_ok = 1'b1;
                    else if (rd_now && stat_armed_reg[i][ridx])
                        rd_idx_ok = 1'b1;
                end
                if (rd_idx_ok)
                begin
                    ccf_reg[i][ridx] <= 1'b0;
                    stat_armed_reg[i][ridx] <= 1'b0;
                    // A completion in the same cycle wins over the clear
                    // serviced clears flag
                    if (!done_now)
                        iflag_reg[i] <= 1'b0;
                end
                if (rd_now && sel && ap_page && ap_off[3] && ctl2_reg[i][`C2_FAST_FLAG_CLEAR] && first_read_reg[i]
                    && !done_now)
                begin
                    seq_done_reg[i] <= 1'b0;
                    first_read_reg[i] <= 1'b0;
                end
                // Register writes
                if (wr_now && sel && !ap_page)
                begin
                    if (ap_off == `OFF_CTL2)
                        ctl2_reg[i] <= {hwdata[7:1], 1'b0};
                    if (ap_off == `OFF_CTL3)
                        ctl3_reg[i] <= hwdata[7:0];
                    if (ap_off == `OFF_CTL4)
                        ctl4_reg[i] <= hwdata[7:0];
                    if (ap_off == `OFF_CTL5)
                        ctl5_reg[i] <= hwdata[7:0];
                    if (ap_off == `OFF_CTL4 || ap_off == `OFF_CTL5)
                    begin
                        busy_reg[i] <= 1'b1;
                        cyc_reg[i] <= 8'h00;
                        conv_idx_reg[i] <= 2'b00;
                        ccf_reg[i] <= {NUM_CONV{1'b0}};
                        seq_done_reg[i] <= 1'b0;
                        iflag_reg[i] <= 1'b0;
                        stat_armed_reg[i] <= {NUM_CONV{1'b0}};
                        first_read_reg[i] <= 1'b1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result justification
    function [15:0] justify;
        input [9:0] raw;
        input resolution_select;
        input right;
        begin
            case ({resolution_select, right})
                2'b00: justify = {raw[9:2], 8'h00};
                2'b01: justify = {8'h00, raw[9:2]};
                2'b10: justify = {raw, 6'h00};
                default: justify = {6'h00, raw};
            endcase
        end
    endfunction

    // Read mux, registered onto hrdata one cycle after the address phase
    reg [31:0] rd_mux;
    wire ci = haddr[`INST_BIT];
    always @*
    begin
        rd_mux = 32'h0000_0000;
        if (!haddr[`PAGE_BIT])
        begin
            case (haddr[3:0])
                `OFF_CTL2: rd_mux = {24'h000000, ctl2_reg[ci][7:1], iflag_reg[ci]};
                `OFF_CTL3: rd_mux = {24'h000000, ctl3_reg[ci]};
                `OFF_CTL4: rd_mux = {24'h000000, ctl4_reg[ci]};
                `OFF_CTL5: rd_mux = {24'h000000, ctl5_reg[ci]};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
        else if (haddr[3])
            rd_mux = {16'h0000, justify(result_reg[ci][haddr[3:2]], ctl4_reg[ci][`C4_RESOLUTION_SELECT],
                                        ctl2_reg[ci][`C2_JUST])};
        else if (haddr[3:0] == `OFF_STAT)
            rd_mux = {23'h000000, seq_done_reg[ci], {(8 - NUM_CONV){1'b0}}, ccf_reg[ci]};
        else if (haddr[3:0] == `OFF_PORT)
            rd_mux = {24'h000000, ci ? pin_level_1 : pin_level_0};
    end

    // Read data and outputs, all from flip-flops
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hrdata <= 32'h0000_0000;
            irq <= 2'b00;
            analog_powered <= 2'b00;
        end
        else
        begin
            if (take && !hwrite)
                hrdata <= rd_mux;
            for (j = 0; j < 2; j = j + 1)
            begin
                irq[j] <= iflag_reg[j] && ctl2_reg[j][`C2_IE];
                analog_powered[j] <= ctl2_reg[j][`C2_PWR] && !(ctl2_reg[j][`C2_HALTW] && cpu_wait);
            end
        end
    end

endmodule
`default_nettype wire

// ===== adc_ctl_asserts.sv
// Checker for the converter control block, bound to its ports
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_consts.vh"
module adc_ctl_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins and state
    input wire logic [7:0] pin_level_0,
    input wire logic [7:0] pin_level_1,
    input wire logic cpu_wait,
    input wire logic [1:0] irq,
    input wire logic [1:0] analog_powered
);
    logic pw;
    logic [7:0] pa;
    logic [7:0] c0;
    wire rd_t = hsel && hready && htrans == `HTRANS_NONSEQ && !hwrite;
    wire start = pw && (pa == 8'h08 || pa == 8'h0C);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    // Shadow of control two, instance 0; data lands one cycle after the address
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pw <= 1'b0;
            pa <= 8'h00;
            c0 <= 8'h00;
        end
        else
        begin
            pw <= hsel && hready && htrans == `HTRANS_NONSEQ && hwrite;
            pa <= haddr;
            if (pw && pa == 8'h00)
                c0 <= hwdata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////
    rdy_always_a: assert property (hreadyout) else $error("bus stalled");
    resp_okay_a: assert property (!hresp) else $error("error response");
    reset_quiet_a: assert property ($rose(rst_n) |-> irq == 2'h0 && analog_powered == 2'h0)
        else $error("outputs active after reset");
    power_state_a: assert property (c0 == $past(c0) && cpu_wait == $past(cpu_wait)
        |-> analog_powered[0] == (c0[7] && !(c0[5] && cpu_wait))) else $error("power state wrong");
    irq_gate_a: assert property (((c0 | $past(c0)) & 8'h02) == 8'h00 |-> !irq[0])
        else $error("request while disabled");
    restart_irq_a: assert property (start && c0[7] |-> ##2 !irq[0])
        else $error("request survives restart");
    ctl_readback_a: assert property (rd_t && haddr == 8'h00 |=>
        (hrdata & 32'hFFFFFFF2) == ($past(c0) & 8'hF2)) else $error("control readback wrong");
    port0_read_a: assert property (rd_t && haddr == 8'h14 |=> hrdata == {24'h0, $past(pin_level_0)})
        else $error("port 0 read wrong");
    port1_read_a: assert property (rd_t && haddr == 8'h34 |=> hrdata == {24'h0, $past(pin_level_1)})
        else $error("port 1 read wrong");
    cover property (irq[0]);
    cover property (start && c0[7]);
    cover property ($rose(analog_powered[0]));
endmodule
bind adc_control_flags_port adc_ctl_checker chk_i (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pin_level_0, .pin_level_1, .cpu_wait, .irq,
    .analog_powered);
`default_nettype wire

// ===== analog_front.sv
// Model of the analog side: pin levels and converter result words
`timescale 1ns/1ps
`default_nettype none
module analog_front (
    // Value the bench wants the inputs to show
    input wire logic [9:0] code,
    // Digital pin levels
    output wire logic [7:0] pin_level_0,
    output wire logic [7:0] pin_level_1,
    // Raw converter words
    output wire logic [9:0] sar_result_0,
    output wire logic [9:0] sar_result_1
);
    // Pins of the two instances differ so a swapped map shows up
    assign pin_level_0 = code[7:0];
    assign pin_level_1 = ~code[7:0];
    assign sar_result_0 = code;
    assign sar_result_1 = code;
endmodule
`default_nettype wire

// ===== tb_adc_control_flags_port.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_consts.vh"
module tb_adc_control_flags_port;
    localparam int CC = 2;
    logic mclk, rst_n, hsel, hwrite, cpu_wait;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, rd;
    logic [9:0] code;
    wire [31:0] hrdata;
    wire hreadyout, hresp;
    wire [1:0] irq, analog_powered;
    wire [7:0] pin_level_0, pin_level_1;
    wire [9:0] sar_result_0, sar_result_1;
    int miscompares, n_tests;
    ////////////////////////////////////////////////////////////
    // Short conversions keep the run brief
    adc_control_flags_port #(.CONV_CYCLES(CC)) dut (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_level_0,
        .pin_level_1, .sar_result_0, .sar_result_1, .cpu_wait, .irq, .analog_powered);
    analog_front front (.code, .pin_level_0, .pin_level_1, .sar_result_0, .sar_result_1);
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////
    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One single transfer; read data is taken at the data phase edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= `HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    function logic [31:0] just(input logic [9:0] r, input logic res, input logic rj);
        case ({res, rj})
            2'b00: just = {16'h0, r[9:2], 8'h00};
            2'b01: just = {24'h0, r[9:2]};
            2'b10: just = {16'h0, r, 6'h00};
            default: just = {22'h0, r};
        endcase
    endfunction
    task give_verdict;
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Normal clearing: result read alone must not clear, status read arms it
    task t_seq;
        bus(0, 8'h00, 0);
        chk(rd, 32'h0);
        bus(1, 8'h00, 32'h82);
        cyc(3);
        bus(1, 8'h0C, 0);
        cyc(20);
        chk(irq, 2'h1);
        bus(1, 8'h00, 32'h82);
        bus(0, 8'h00, 0);
        chk(rd, 32'h83);
        bus(1, 8'h04, 0);
        bus(0, 8'h18, 0);
        chk(rd, just(code, 1'b0, 1'b0));
        bus(0, 8'h10, 0);
        chk(rd, 32'h10F);
        bus(0, 8'h18, 0);
        bus(0, 8'h10, 0);
        chk(rd, 32'h10B);
        cyc(2);
        chk(irq, 2'h0);
    endtask
    // Every format in fast clear mode, restarted through control four
    task t_fmt;
        for (int i = 0; i < 4; i++)
        begin
            bus(1, 8'h00, {24'h0, 3'h6, i[0], 4'h0});
            bus(1, 8'h08, {24'h0, i[1], 7'h0});
            bus(0, 8'h10, 0);
            chk(rd, 32'h0);
            cyc(20);
            bus(0, 8'h18, 0);
            chk(rd, just(code, i[1], i[0]));
            bus(0, 8'h10, 0);
            chk(rd, 32'h00B);
        end
    endtask
    // Wait mode halts a sequence, which then finishes without restart
    task t_wait;
        bus(1, 8'h00, 32'hA0);
        bus(1, 8'h0C, 0);
        cpu_wait <= 1'b1;
        cyc(30);
        chk(analog_powered, 2'h0);
        bus(0, 8'h10, 0);
        chk(rd, 32'h0);
        cpu_wait <= 1'b0;
        cyc(20);
        chk(analog_powered, 2'h1);
        bus(0, 8'h10, 0);
        chk(rd, 32'h10F);
        bus(1, 8'h00, 32'h80);
        cpu_wait <= 1'b1;
        cyc(3);
        chk(analog_powered, 2'h1);
        // Restart held by wait, then power off: powering up again must not resume it
        bus(1, 8'h00, 32'hA0);
        bus(1, 8'h0C, 0);
        bus(1, 8'h00, 32'h00);
        cpu_wait <= 1'b0;
        cyc(20);
        chk(analog_powered, 2'h0);
        bus(1, 8'h00, 32'h80);
        cyc(20);
        bus(0, 8'h10, 0);
        chk(rd, 32'h0);
        bus(1, 8'h00, 32'h00);
    endtask
    // Second instance, port reads during a sequence, then reset
    task t_port;
        bus(1, 8'h20, 32'h80);
        cyc(2);
        chk(analog_powered, 2'h2);
        bus(1, 8'h2C, 0);
        bus(0, 8'h34, 0);
        chk(rd, {24'h0, ~code[7:0]});
        cyc(20);
        bus(0, 8'h30, 0);
        chk(rd, 32'h10F);
        bus(0, 8'h14, 0);
        chk(rd, {24'h0, code[7:0]});
        bus(1, 8'h20, 32'h82);
        cyc(3);
        chk(irq, 2'h2);
        rst_n <= 1'b0;
        cyc(2);
        chk(irq, 2'h0);
        rst_n <= 1'b1;
        bus(0, 8'h20, 0);
        chk(rd, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n, hsel, hwrite, cpu_wait, haddr, htrans, hwdata} = '0;
        code = 10'h2D7;
        cyc(20);
        rst_n <= 1'b1;
        t_seq;
        t_fmt;
        t_wait;
        t_port;
        give_verdict;
    end
    // The whole run needs about 350 cycles
    initial
    begin
        #40us;
        miscompares++;
        give_verdict;
    end
endmodule
`default_nettype wire
